// ==== rtl/fram_defines.svh ====
// opcode, status field and address constants for the serial fram core
`ifndef FRAM_DEFINES_SVH
`define FRAM_DEFINES_SVH

// command opcodes
`define OP_SET_LATCH   8'h06
`define OP_CLR_LATCH   8'h04
`define OP_STAT_RD     8'h05
`define OP_STAT_WR     8'h01
`define OP_READ        8'h03
`define OP_LAT_READ    8'h0B
`define OP_WRITE       8'h02

// status byte field positions
`define ST_PROTECT_PIN_ENABLE        7
`define ST_FIX_ONE     6
`define ST_BP_HIGH     3
`define ST_BP_LOW      2
`define ST_WEL         1
`define ST_FIXED_ONES  8'h40

// retained protect bits {enable, bp_high, bp_low} at first power
`define NV_RESET       3'h0

// address space
`define ADDR_W         18
`define MEM_DEPTH      262144
`define ADDR_LAST      18'h3FFFF
`define ADDR_FIRST     18'h00000
`define BP_QUARTER     18'h30000
`define BP_HALF        18'h20000
`define ADDR_BYTE_LAST 2'h2
`define BIT_LAST       3'h7

`endif

// ==== rtl/fram_pkg.sv ====
// types and helper functions for the serial fram core
package fram_pkg;
`include "fram_defines.svh"

   typedef enum logic [3:0] {
      S_IDLE, S_OPCODE, S_ADDR, S_DUMMY, S_WDATA, S_RDATA, S_SRD, S_SWR, S_IGNORE
   } phase_t;

   typedef struct packed {
      phase_t              phase;
      logic [2:0]          bit_cnt;
      logic [1:0]          byte_cnt;
      logic [23:0]         shreg;
      logic [7:0]          opcode;
      logic [`ADDR_W-1:0]  addr;
      logic [6:0]          tx;
      logic                write_enable_latch;
      logic                end_clr;
      logic                so;
      logic                so_oe;
   } core_t;

   typedef struct packed {
      logic [2:0] cs;
      logic [2:0] sck;
      logic [1:0] si;
      logic [1:0] wp;
   } sync_t;

   // address counter step with wrap at the top
   function automatic logic [`ADDR_W-1:0] addr_inc(input logic [`ADDR_W-1:0] a);
      return (a == `ADDR_LAST) ? `ADDR_FIRST : a + 18'h00001;
   endfunction : addr_inc

   // block protect decode
   function automatic logic in_protected(input logic [1:0] bp,
                                         input logic [`ADDR_W-1:0] a);
      case (bp)
         2'h0:    return 1'b0;
         2'h1:    return a >= `BP_QUARTER;
         2'h2:    return a >= `BP_HALF;
         default: return 1'b1;
      endcase
   endfunction : in_protected

   // status byte image, nv = {enable, bp_high, bp_low}
   function automatic logic [7:0] status_byte(input logic [2:0] nv, input logic write_enable_latch);
      logic [7:0] b;
      b = `ST_FIXED_ONES;
      b[`ST_PROTECT_PIN_ENABLE] = nv[2];
      b[`ST_BP_HIGH] = nv[1];
      b[`ST_BP_LOW] = nv[0];
      b[`ST_WEL] = write_enable_latch;
      return b;
   endfunction : status_byte

endpackage : fram_pkg

// ==== rtl/spi_evt_if.sv ====
// synchronised pin events passed from the pin sampler to the core
`timescale 1ns/1ns
`default_nettype none
interface spi_evt_if;
   logic cs_fall;
   logic cs_rise;
   logic selected;
   logic sck_rise;
   logic sck_fall;
   logic si;
   logic wp_n;
   modport src  (output cs_fall, cs_rise, selected, sck_rise, sck_fall, si, wp_n);
   modport sink (input  cs_fall, cs_rise, selected, sck_rise, sck_fall, si, wp_n);
endinterface : spi_evt_if
`default_nettype wire

// ==== rtl/spi_pin_sync.sv ====
// two-flop pin sampler and edge detector for the serial pins
`timescale 1ns/1ns
`default_nettype none
module spi_pin_sync
   import fram_pkg::*;
(
   // clock and reset
   input  wire logic i_clk,
   input  wire logic i_resetn,
   // raw pins
   input  wire logic i_cs_n,
   input  wire logic i_sck,
   input  wire logic i_si,
   input  wire logic i_wp_n,
   // events to the core
   spi_evt_if.src    evt
);
   sync_t st;
   sync_t next_st;

   // shift chains; stage 0 feeds only stage 1
   always_comb
   begin
      next_st.cs  = {st.cs[1:0], i_cs_n};
      next_st.sck = {st.sck[1:0], i_sck};
      next_st.si  = {st.si[0], i_si};
      next_st.wp  = {st.wp[0], i_wp_n};
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_resetn)
      begin
         st <= '{cs: 3'h7, sck: 3'h0, si: 2'h0, wp: 2'h3};
      end
      else
      begin
         st <= next_st;
      end
   end

   // edges compare stage 1 with stage 2; si stays aligned with sck
   assign evt.cs_fall  = st.cs[2] & ~st.cs[1];
   assign evt.cs_rise  = ~st.cs[2] & st.cs[1];
   assign evt.selected = ~st.cs[1];
   assign evt.sck_rise = ~st.sck[2] & st.sck[1];
   assign evt.sck_fall = st.sck[2] & ~st.sck[1];
   assign evt.si       = st.si[1];
   assign evt.wp_n     = st.wp[1];

endmodule : spi_pin_sync
`default_nettype wire

// ==== rtl/fram_core.sv ====
// command, protection and array logic of the serial fram slave
//
// How it works
// - status bits 0,4,5 zero, bit 6 one
// - status bit 1 mirrors latch, opcodes only
// - write latch clear after power up
// - block protect bits at 2,3, nonvolatile
// - protect settings none, quarter, half, all
// - enable bit plus low pin blocks status write
// - array writes blocked by latch or range
// - protect pin gates status writes only
// - status write updates 7,3,2; clears latch
// - status read shifts out status byte
// - three address bytes, low 18 bits used
// - data bytes stored, address wraps to zero
// - commit on eighth bit, partial byte dropped
// - protected address stops write and increment
// - read drives data MSB first, ignores input
// - read wraps; select high floats output
// - latency read adds one dummy byte
// - latency read data ignores input, ends likewise
// - busy bit always zero, no sleep here
// - eight bit opcodes as listed
// - sample on rising, shift on falling
// - latch clears when clearing commands end
// - unknown opcode ignored until next select
`timescale 1ns/1ns
`default_nettype none
module fram_core
   import fram_pkg::*;
(
   // clock and reset
   input  wire logic i_clk,
   input  wire logic i_resetn,
   // serial bus pins
   input  wire logic i_cs_n,
   input  wire logic i_sck,
   input  wire logic i_si,
   input  wire logic i_wp_n,
   // serial output pin, enable high while driven
   output var  logic o_so,
   output var  logic o_so_oe
);
`include "fram_defines.svh"

   spi_evt_if evt ();

   spi_pin_sync u_sync (
      .i_clk    (i_clk),
      .i_resetn (i_resetn),
      .i_cs_n   (i_cs_n),
      .i_sck    (i_sck),
      .i_si     (i_si),
      .i_wp_n   (i_wp_n),
      .evt      (evt)
   );

   core_t               st;
   core_t               next_st;
   logic [7:0]          mem [`MEM_DEPTH];
   logic [2:0]          nv = `NV_RESET;
   logic [2:0]          next_nv;
   logic                nv_we;
   logic                wr_en;
   logic [`ADDR_W-1:0]  wr_addr;
   logic [7:0]          wr_data;
   logic [23:0]         sh_in;
   logic [7:0]          byte_in;
   logic [7:0]          status_now;
   logic [7:0]          mem_rd;
   logic                rise_ok;
   logic                fall_ok;
   logic                byte_done;
   logic                swr_ok;

   // qualified edges; select edges win over clock edges
   assign rise_ok   = evt.selected & evt.sck_rise & ~evt.cs_rise & ~evt.cs_fall;
   assign fall_ok   = evt.selected & evt.sck_fall & ~evt.cs_rise & ~evt.cs_fall;
   assign byte_done = rise_ok & (st.bit_cnt == `BIT_LAST);
   assign sh_in     = {st.shreg[22:0], evt.si};
   assign byte_in   = sh_in[7:0];
   // fixed bits come from the image
   assign status_now = status_byte(nv, st.write_enable_latch);
   assign mem_rd    = mem[st.addr];
   // pin only counts with enable set
   assign swr_ok    = st.write_enable_latch & ~(nv[2] & ~evt.wp_n);

   // next state of the command engine
   always_comb
   begin
      next_st = st;
      wr_en   = 1'b0;
      wr_addr = st.addr;
      wr_data = byte_in;
      nv_we   = 1'b0;
      next_nv = nv;
      if (evt.cs_rise)
      begin
         next_st.phase  = S_IDLE;
         next_st.so_oe  = 1'b0;
         next_st.so     = 1'b0;
         if (st.end_clr)
         begin
            next_st.write_enable_latch = 1'b0;
         end
         next_st.end_clr = 1'b0;
      end
      else if (evt.cs_fall)
      begin
         next_st.phase    = S_OPCODE;
         next_st.bit_cnt  = 3'h0;
         next_st.byte_cnt = 2'h0;
         next_st.so_oe    = 1'b0;
      end
      else if (rise_ok)
      begin
         next_st.shreg   = sh_in;
         next_st.bit_cnt = st.bit_cnt + 3'h1;
         if (byte_done)
         begin
            unique case (st.phase)
               S_OPCODE:
               begin
                  next_st.opcode = byte_in;
                  case (byte_in)
                     `OP_SET_LATCH:
                     begin
                        next_st.write_enable_latch   = 1'b1;
                        next_st.phase = S_IGNORE;
                     end
                     `OP_CLR_LATCH:
                     begin
                        next_st.end_clr = 1'b1;
                        next_st.phase   = S_IGNORE;
                     end
                     `OP_STAT_RD:
                     begin
                        next_st.phase = S_SRD;
                     end
                     `OP_STAT_WR:
                     begin
                        next_st.end_clr = 1'b1;
                        next_st.phase   = S_SWR;
                     end
                     `OP_READ, `OP_LAT_READ:
                     begin
                        next_st.phase = S_ADDR;
                     end
                     `OP_WRITE:
                     begin
                        next_st.end_clr = 1'b1;
                        next_st.phase   = S_ADDR;
                     end
                     default:
                     begin
                        next_st.phase = S_IGNORE;
                     end
                  endcase
               end
               S_ADDR:
               begin
                  next_st.byte_cnt = st.byte_cnt + 2'h1;
                  if (st.byte_cnt == `ADDR_BYTE_LAST)
                  begin
                     next_st.addr = sh_in[`ADDR_W-1:0];
                     if (st.opcode == `OP_WRITE)
                     begin
                        next_st.phase = S_WDATA;
                     end
                     else if (st.opcode == `OP_LAT_READ)
                     begin
                        next_st.phase = S_DUMMY;
                     end
                     else
                     begin
                        next_st.phase = S_RDATA;
                     end
                  end
               end
               S_DUMMY:
               begin
                  next_st.phase = S_RDATA;
               end
               S_WDATA:
               begin
                  if (st.write_enable_latch && !in_protected(nv[1:0], st.addr))
                  begin
                     wr_en = 1'b1;
                     next_st.addr = addr_inc(st.addr);
                  end
                  else
                  begin
                     next_st.phase = S_IGNORE;
                  end
               end
               S_RDATA:
               begin
                  next_st.addr = addr_inc(st.addr);
               end
               S_SWR:
               begin
                  // only enable and protect bits taken
                  if (swr_ok)
                  begin
                     nv_we   = 1'b1;
                     next_nv = {byte_in[`ST_PROTECT_PIN_ENABLE], byte_in[`ST_BP_HIGH], byte_in[`ST_BP_LOW]};
                  end
                  next_st.phase = S_IGNORE;
               end
               default:
               begin
                  next_st.phase = st.phase;
               end
            endcase
         end
      end
      else if (fall_ok && (st.phase == S_RDATA || st.phase == S_SRD))
      begin
         // MSB first, fresh byte at bit zero
         next_st.so_oe = 1'b1;
         if (st.bit_cnt == 3'h0)
         begin
            {next_st.so, next_st.tx} = (st.phase == S_SRD) ? status_now : mem_rd;
         end
         else
         begin
            next_st.so = st.tx[6];
            next_st.tx = {st.tx[5:0], 1'b0};
         end
      end
   end

   // latch and output cleared by reset
   always_ff @(posedge i_clk)
   begin
      if (!i_resetn)
      begin
         st <= '{phase: S_IDLE, default: '0};
      end
      else
      begin
         st <= next_st;
      end
   end

   // protect bits held apart from the state
   // no reset here, they must survive it
   always_ff @(posedge i_clk)
   begin
      if (nv_we)
      begin
         nv <= next_nv;
      end
   end

   // array store; contents are not reset
   always_ff @(posedge i_clk)
   begin
      if (wr_en)
      begin
         mem[wr_addr] <= wr_data;
      end
   end

   // outputs straight from flops
   assign o_so    = st.so;
   assign o_so_oe = st.so_oe;

   // checks on the command engine
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_resetn);

   property p_fixed_bits;
      status_now[0] == 1'b0 && status_now[5:4] == 2'h0 && status_now[6] == 1'b1
         && status_now[1] == st.write_enable_latch;
   endproperty
   a_fixed_bits: assert property (p_fixed_bits) else $error("status fixed bits wrong");

   property p_swr_keeps_wel;
      (st.phase == S_SWR && byte_done) |=> st.write_enable_latch == $past(st.write_enable_latch);
   endproperty
   a_swr_keeps_wel: assert property (p_swr_keeps_wel) else $error("status write moved latch");

   property p_reset_wel;
      disable iff (1'b0) !i_resetn |=> !st.write_enable_latch && !o_so_oe;
   endproperty
   a_reset_wel: assert property (p_reset_wel) else $error("latch set after reset");

   property p_nv_gate;
      $changed(nv) |-> $past(st.phase == S_SWR && byte_done && st.write_enable_latch
         && !(nv[2] && !evt.wp_n));
   endproperty
   a_nv_gate: assert property (p_nv_gate) else $error("protect bits changed without leave");

   property p_wr_allowed;
      wr_en |-> st.write_enable_latch && !in_protected(nv[1:0], wr_addr) && st.phase == S_WDATA;
   endproperty
   a_wr_allowed: assert property (p_wr_allowed) else $error("array write not permitted");

   property p_wr_step;
      wr_en |=> st.addr == addr_inc($past(wr_addr));
   endproperty
   a_wr_step: assert property (p_wr_step) else $error("write address step wrong");

   property p_prot_stop;
      (st.phase == S_WDATA && byte_done && in_protected(nv[1:0], st.addr))
         |=> st.phase == S_IGNORE && $stable(st.addr) ##1 !wr_en [*3];
   endproperty
   a_prot_stop: assert property (p_prot_stop) else $error("protected write not halted");

   property p_end_clear;
      (evt.cs_rise && st.end_clr) |=> !st.write_enable_latch;
   endproperty
   a_end_clear: assert property (p_end_clear) else $error("latch not cleared at end");

   property p_float_end;
      evt.cs_rise |=> !o_so_oe;
   endproperty
   a_float_end: assert property (p_float_end) else $error("output driven after select high");

   property p_ignore_quiet;
      st.phase == S_IGNORE |-> !o_so_oe && !wr_en;
   endproperty
   a_ignore_quiet: assert property (p_ignore_quiet) else $error("activity in ignore phase");

   property p_read_msb;
      (st.phase == S_RDATA && fall_ok && st.bit_cnt == 3'h0)
         |=> o_so == $past(mem_rd[7]) && o_so_oe;
   endproperty
   a_read_msb: assert property (p_read_msb) else $error("read data bit wrong");

   property p_status_msb;
      (st.phase == S_SRD && fall_ok && st.bit_cnt == 3'h0)
         |=> o_so == $past(status_now[7]) && o_so_oe;
   endproperty
   a_status_msb: assert property (p_status_msb) else $error("status bit wrong");

   property p_dummy_quiet;
      st.phase == S_DUMMY |-> !o_so_oe;
   endproperty
   a_dummy_quiet: assert property (p_dummy_quiet) else $error("output during dummy byte");

   c_write: cover property (wr_en ##[1:400] wr_en);
   c_prot: cover property (st.phase == S_WDATA && byte_done && in_protected(nv[1:0], st.addr));
   c_lat: cover property (st.phase == S_DUMMY ##[1:200] st.phase == S_RDATA && o_so_oe);
   c_swr: cover property (nv_we);

endmodule : fram_core
`default_nettype wire

// ==== verification/spi_host.sv ====
// bus host model that drives the serial pins of the fram core
`timescale 1ns/1ns
`default_nettype none
module spi_host
(
   // clock
   input  wire logic       i_clk,
   // pins toward the device
   output var  logic       o_cs_n,
   output var  logic       o_sck,
   output var  logic       o_si,
   input  wire logic       i_so,
   input  wire logic       i_so_oe,
   // byte seen on the output line
   output var  logic [7:0] o_rx_byte,
   output var  logic       o_rx_valid,
   output var  logic       o_oe_seen
);
   // half period of 5 clocks, above the 3 that the pin sampler needs
   localparam int HALF = 5;
   logic mode3;
   logic so_last;
   // a floating line shows the inverse of its last value, never a stale copy
   wire logic so_line = i_so_oe ? i_so : ~so_last;

   // idle pins at time zero
   initial
   begin
      o_cs_n = 1'b1;
      o_sck = 1'b0;
      o_si = 1'b0;
      o_rx_byte = 8'h00;
      o_rx_valid = 1'b0;
      o_oe_seen = 1'b0;
      so_last = 1'b0;
      mode3 = 1'b0;
   end

   // last driven level, and any drive while selected
   always @(posedge i_clk)
   begin
      if (i_so_oe)
         so_last <= i_so;
      if (i_so_oe && !o_cs_n)
         o_oe_seen <= 1'b1;
   end

   // sck idle level picks mode 0 or 3
   task automatic select(input logic m3);
      mode3 = m3;
      o_sck <= m3;
      repeat (HALF) @(negedge i_clk);
      o_cs_n <= 1'b0;
      o_oe_seen <= 1'b0;
      repeat (HALF) @(negedge i_clk);
   endtask : select

   // msb first, data set on fall, sampled on rise
   task automatic xfer(input logic [7:0] tx, input int nbits, input logic chk);
      logic [7:0] rx;
      rx = 8'h00;
      for (int i = 7; i > 7 - nbits; i--)
      begin
         o_sck <= 1'b0;
         o_si <= tx[i];
         repeat (HALF) @(negedge i_clk);
         o_sck <= 1'b1;
         rx = {rx[6:0], so_line};
         repeat (HALF) @(negedge i_clk);
      end
      o_rx_byte <= rx;
      o_rx_valid <= chk;
      @(negedge i_clk);
      o_rx_valid <= 1'b0;
   endtask : xfer

   // end of select; released data line toggles
   // mode 0 clock drops only after select is high, so no extra fall
   // reaches the core and fetches an unwritten byte into the output
   task automatic deselect();
      repeat (HALF) @(negedge i_clk);
      o_cs_n <= 1'b1;
      o_si <= ~o_si;
      repeat (HALF) @(negedge i_clk);
      if (!mode3)
         o_sck <= 1'b0;
      repeat (HALF) @(negedge i_clk);
   endtask : deselect
endmodule : spi_host
`default_nettype wire

// ==== verification/spi_fram_protect_and_access_tb.sv ====
// self-checking bench for the fram core, driven through the bus host model
`timescale 1ns/1ns
`default_nettype none
`include "fram_defines.svh"
module spi_fram_protect_and_access_tb;
   logic        clk;
   logic        resetn;
   logic        wp_n;
   logic        cs_n;
   logic        sck;
   logic        si;
   logic        so;
   logic        so_oe;
   logic        rx_valid;
   logic        oe_seen;
   logic [7:0]  rx_byte;
   logic [31:0] seed = 32'hC74E;
   logic [7:0]  mem [int];
   logic [7:0]  exp_q [$];
   logic [2:0]  nv = 3'h0;
   logic [17:0] adr [6] = '{18'h3FFFF, 18'h30000, 18'h2FFFF, 18'h20000, 18'h1FFFF, 18'h00000};
   logic [7:0]  bad [3] = '{8'h9F, 8'hB9, 8'hFF};
   int          err_count = 0;
   int          cmp_count = 0;

   fram_core i_fram_core (.i_clk(clk), .i_resetn(resetn), .i_cs_n(cs_n), .i_sck(sck),
      .i_si(si), .i_wp_n(wp_n), .o_so(so), .o_so_oe(so_oe));
   spi_host i_spi_host (.i_clk(clk), .o_cs_n(cs_n), .o_sck(sck), .o_si(si), .i_so(so),
      .i_so_oe(so_oe), .o_rx_byte(rx_byte), .o_rx_valid(rx_valid), .o_oe_seen(oe_seen));

   // 250 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   function automatic logic [7:0] rnd();
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed[7:0];
   endfunction : rnd

   task automatic check(input logic [7:0] seen, input logic [7:0] expd);
      cmp_count++;
      if (seen !== expd)
      begin
         err_count++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, expd);
      end
   endtask : check

   // each received byte is matched against the oldest note
   always @(posedge clk)
      if (rx_valid === 1'b1)
      begin
         if (exp_q.size() > 0)
            check(rx_byte, exp_q.pop_front());
         else
            err_count++;
      end

   task automatic op(input logic [7:0] code);
      i_spi_host.select(1'b0);
      i_spi_host.xfer(code, 8, 1'b0);
      i_spi_host.deselect();
   endtask : op

   task automatic send_addr(input logic [23:0] a24);
      i_spi_host.xfer(a24[23:16], 8, 1'b0);
      i_spi_host.xfer(a24[15:8], 8, 1'b0);
      i_spi_host.xfer(a24[7:0], 8, 1'b0);
   endtask : send_addr

   // expected status: enable, fixed 100, protect bits, latch, zero
   task automatic stat_rd(input logic write_enable_latch);
      exp_q.push_back({nv[2], 3'h4, nv[1:0], write_enable_latch, 1'b0});
      i_spi_host.select(1'b0);
      i_spi_host.xfer(`OP_STAT_RD, 8, 1'b0);
      i_spi_host.xfer(rnd(), 8, 1'b1);
      i_spi_host.deselect();
   endtask : stat_rd

   // latch set first; only enable and protect bits change
   task automatic stat_wr(input logic [7:0] v);
      op(`OP_SET_LATCH);
      i_spi_host.select(1'b0);
      i_spi_host.xfer(`OP_STAT_WR, 8, 1'b0);
      i_spi_host.xfer(v, 8, 1'b0);
      i_spi_host.deselect();
      if (!(nv[2] && !wp_n))
         nv = {v[7], v[3], v[2]};
      stat_rd(1'b0);
   endtask : stat_wr

   // set latch in its own select, then the write burst
   task automatic wr_mem(input logic [23:0] a24, input int n, input logic latch);
      logic [17:0] a;
      logic [7:0]  d;
      logic        stop;
      a = a24[17:0];
      stop = !latch;
      if (latch)
         op(`OP_SET_LATCH);
      i_spi_host.select(1'b0);
      i_spi_host.xfer(`OP_WRITE, 8, 1'b0);
      send_addr(a24);
      repeat (n)
      begin
         d = rnd();
         i_spi_host.xfer(d, 8, 1'b0);
         stop = stop | (nv[1:0] == 2'h3) | (nv[1:0] == 2'h1 && a >= 18'h30000)
                | (nv[1:0] == 2'h2 && a >= 18'h20000);
         if (!stop)
         begin
            mem[a] = d;
            a = a + 18'h00001;
         end
      end
      i_spi_host.xfer(rnd(), 4, 1'b0);
      i_spi_host.deselect();
   endtask : wr_mem

   task automatic rd_mem(input logic [23:0] a24, input int n, input logic fast, input logic m3);
      logic [17:0] a;
      a = a24[17:0];
      i_spi_host.select(m3);
      i_spi_host.xfer(fast ? `OP_LAT_READ : `OP_READ, 8, 1'b0);
      send_addr(a24);
      if (fast)
      begin
         i_spi_host.xfer(rnd(), 8, 1'b0);
         check({7'h00, oe_seen}, 8'h00);
      end
      repeat (n)
      begin
         exp_q.push_back(mem[a]);
         a = a + 18'h00001;
         i_spi_host.xfer(rnd(), 8, 1'b1);
      end
      i_spi_host.deselect();
      check({7'h00, so_oe}, 8'h00);
   endtask : rd_mem

   task automatic bad_op(input logic [7:0] code);
      i_spi_host.select(1'b0);
      i_spi_host.xfer(code, 8, 1'b0);
      repeat (3) i_spi_host.xfer(rnd(), 8, 1'b0);
      check({7'h00, oe_seen}, 8'h00);
      i_spi_host.deselect();
   endtask : bad_op

   task automatic done(input string name);
      $display("test %s finished", name);
   endtask : done

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : summarize

   // about 50k clocks expected; 400 us leaves ample margin
   initial
   begin
      #400000;
      err_count++;
      summarize();
   end

   // main sequence
   initial
   begin
      logic [1:0] bp2;
      resetn = 1'b0;
      wp_n = 1'b1;
      repeat (8) @(negedge clk);
      resetn <= 1'b1;
      repeat (4) @(negedge clk);
      // fixed bits and latch set and clear
      stat_rd(1'b0);
      op(`OP_SET_LATCH);
      stat_rd(1'b1);
      op(`OP_CLR_LATCH);
      stat_rd(1'b0);
      foreach (bad[i]) bad_op(bad[i]);
      stat_rd(1'b0);
      done("status");
      // every protect setting at the boundaries, top bits junk
      for (int bp = 0; bp < 5; bp++)
      begin
         bp2 = bp[1:0];
         stat_wr({1'b0, 3'h7, bp2, 2'h3});
         foreach (adr[i]) wr_mem({6'h2A, adr[i]}, 1, 1'b1);
         foreach (adr[i]) rd_mem({6'h15, adr[i]}, 1, seed[0], seed[1]);
         wr_mem(24'h02FFFF, 3, 1'b1);
         rd_mem(24'h02FFFF, 3, seed[2], seed[3]);
      end
      done("protect");
      // wrap at the top, latency read in mode 3; latch clear
      wr_mem(24'hFFFFFE, 3, 1'b1);
      rd_mem(24'h03FFFE, 3, 1'b1, 1'b1);
      wr_mem(24'h000010, 1, 1'b1);
      wr_mem(24'h000010, 1, 1'b0);
      rd_mem(24'h000010, 1, 1'b0, 1'b0);
      done("wrap");
      // pin ignored unless enabled, and never blocks the array
      wp_n <= 1'b0;
      stat_wr(8'h80);
      stat_wr(8'h8C);
      wr_mem(24'h012345, 2, 1'b1);
      rd_mem(24'h012345, 2, 1'b0, 1'b1);
      wp_n <= 1'b1;
      stat_wr(8'h0C);
      // protect bits survive a logic reset, latch does not
      op(`OP_SET_LATCH);
      resetn <= 1'b0;
      repeat (8) @(negedge clk);
      resetn <= 1'b1;
      repeat (4) @(negedge clk);
      stat_rd(1'b0);
      stat_wr(8'h00);
      done("pin and reset");
      repeat (10) @(negedge clk);
      summarize();
   end
endmodule : spi_fram_protect_and_access_tb
`default_nettype wire
